// ==== dma_device_bank_select.sv ====
// dma routing and bank-select register with peripheral and bank steering
`timescale 1ns/1ps
module dma_device_bank_select (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  input  wire logic [7:0] io_addr_in,
  input  wire logic [7:0] io_wdata_in,
  input  wire logic       io_wr_in,
  input  wire logic       io_rd_in,
  input  wire logic       dma_active_in,
  input  wire logic       dma_mem_wr_in,
  input  wire logic       floppy_controller_req_in,
  input  wire logic       scsi_req_in,
  input  wire logic       dma_ack_in,
  output logic            dma_ctrl_cs_q_out,
  output logic            dev_sel_q_out,
  output logic            src_bank_q_out,
  output logic            dst_bank_q_out,
  output logic            ram_bank_q_out,
  output logic            rom_en_q_out,
  output logic            dma_req_q_out,
  output logic            floppy_controller_ack_q_out,
  output logic            scsi_ack_q_out
);

  // stored register fields, in this order
  localparam int NUM_FIELDS = 3;
  localparam int FIELD_DEV  = 0;
  localparam int FIELD_SRC  = 1;
  localparam int FIELD_DST  = 2;

  // bit position of each stored field in the written byte
  localparam int FIELD_POS [NUM_FIELDS] = '{
    dma_route_pkg::BIT_DEVICE,
    dma_route_pkg::BIT_SRC_BANK,
    dma_route_pkg::BIT_DST_BANK
  };

  // rom switching lives outside this block; here it can only be vetoed
  localparam logic ROM_IN_DMA_MAP = 1'b0;

  // register state
  logic [NUM_FIELDS-1:0] field_q;

  // registered outputs
  logic                  cs_q;
  logic                  bank_q;
  logic                  rom_q;

  // peripheral request synchronisers
  logic [dma_route_pkg::NUM_PERIPH-1:0] req_s1_q;
  logic [dma_route_pkg::NUM_PERIPH-1:0] req_s2_q;

  // mux results
  logic [dma_route_pkg::NUM_PERIPH-1:0] ack_q;
  logic                                 req_q;

  // decode and steering nets
  wire                                  addr_is_route;
  wire                                  addr_is_ctrl;
  wire                                  any_strobe;
  wire                                  route_wr;
  wire                                  route_load;
  wire                                  ctrl_hit;
  wire                                  dev_now;
  wire                                  src_now;
  wire                                  dst_now;
  wire                                  bank_d;
  wire                                  rom_d;
  wire [dma_route_pkg::NUM_PERIPH-1:0]  req_pin;

  dma_sel_if sel ();

  // address decode
  assign addr_is_route = (io_addr_in == dma_route_pkg::PORT_ROUTE_SEL);
  assign addr_is_ctrl  = (io_addr_in == dma_route_pkg::PORT_DMA_CTRL);
  assign any_strobe    = io_wr_in || io_rd_in;

  // reads of the routing port fall through: the register is write only
  assign route_wr      = io_wr_in && addr_is_route;
  assign route_load    = ce_in && route_wr;
  assign ctrl_hit      = any_strobe && addr_is_ctrl;

  // named views of the stored fields
  assign dev_now       = field_q[FIELD_DEV];
  assign src_now       = field_q[FIELD_SRC];
  assign dst_now       = field_q[FIELD_DST];

  // steering is one gate level, so no wait cycle is ever needed
  assign bank_d        = dma_mem_wr_in ? dst_now : src_now;

  // constant veto: a dma cycle must never see rom or eprom
  assign rom_d         = ROM_IN_DMA_MAP && !dma_active_in;

  // device select handed to the mux
  assign sel.dev_sel   = dev_now;

  // pins in peripheral order
  assign req_pin[dma_route_pkg::DEV_FLOPPY] = floppy_controller_req_in;
  assign req_pin[dma_route_pkg::DEV_SCSI]   = scsi_req_in;

  // only three bits are stored; the rest of the byte is dropped
  genvar f;
  generate
    for (f = 0; f < NUM_FIELDS; f++) begin : gen_field
      always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
          field_q[f] <= dma_route_pkg::ROUTE_RESET_VAL[FIELD_POS[f]];
        end else if (route_load) begin
          field_q[f] <= io_wdata_in[FIELD_POS[f]];
        end
      end
    end
  endgenerate

  // select pulse toward the dma controller, one per strobe cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cs_q <= 1'b0;
    end else if (ce_in) begin
      cs_q <= ctrl_hit;
    end
  end

  // bank in use, registered once
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      bank_q <= 1'b0;
    end else if (ce_in) begin
      bank_q <= bank_d;
    end
  end

  // rom enable toward the memory decode
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rom_q <= 1'b0;
    end else if (ce_in) begin
      rom_q <= rom_d;
    end
  end

  // peripheral requests come from pins: two flops before any logic
  genvar p;
  generate
    for (p = 0; p < dma_route_pkg::NUM_PERIPH; p++) begin : gen_sync
      always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
          req_s1_q[p] <= 1'b0;
          req_s2_q[p] <= 1'b0;
        end else if (ce_in) begin
          req_s1_q[p] <= req_pin[p];
          req_s2_q[p] <= req_s1_q[p];
        end
      end
    end
  endgenerate

  // request and acknowledge steering for the selected peripheral
  dma_periph_mux #(
    .NUM (dma_route_pkg::NUM_PERIPH)
  ) u_mux (
    .clk_sys_in         (clk_sys_in),
    .rst_in             (rst_in),
    .ce_in              (ce_in),
    .sel                (sel),
    .periph_req_sync_in (req_s2_q),
    .dma_ack_in         (dma_ack_in),
    .dma_req_q          (req_q),
    .periph_ack_q       (ack_q)
  );

  // every output is a flop
  assign dma_ctrl_cs_q_out           = cs_q;
  assign dev_sel_q_out               = field_q[FIELD_DEV];
  assign src_bank_q_out              = field_q[FIELD_SRC];
  assign dst_bank_q_out              = field_q[FIELD_DST];
  assign ram_bank_q_out              = bank_q;
  assign rom_en_q_out                = rom_q;
  assign dma_req_q_out               = req_q;
  assign floppy_controller_ack_q_out = ack_q[dma_route_pkg::DEV_FLOPPY];
  assign scsi_ack_q_out              = ack_q[dma_route_pkg::DEV_SCSI];
endmodule

// ==== dma_device_bank_select_tb_top.sv ====
// random bench for the dma routing and bank-select block
`timescale 1ns/1ps
module dma_device_bank_select_tb_top;
  logic        clk_sys_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, io_wr_in = 1'b0, io_rd_in = 1'b0;
  logic [7:0]  io_addr_in = 8'h00, io_wdata_in = 8'h00, d;
  logic [31:0] rng = 32'haa50_0e69;
  logic        floppy_controller_req_in, scsi_req_in, dma_ack_in, dma_ctrl_cs_q_out;
  logic        dev_sel_q_out, src_bank_q_out, dst_bank_q_out, ram_bank_q_out, rom_en_q_out;
  logic        dma_req_q_out, floppy_controller_ack_q_out, scsi_ack_q_out;
  wire         dma_active_in = dma_ack_in;
  wire         dma_mem_wr_in = rng[2];
  wire  [3:0]  seen = {dma_ctrl_cs_q_out, dev_sel_q_out, src_bank_q_out, dst_bank_q_out};
  int          errors = 0, samples_checked = 0;
  logic        mon_on = 1'b0, exp_bank = 1'b0, exp_req = 1'b0;
  logic [1:0]  exp_ack = 2'b00, pipe1 = 2'b00, pipe2 = 2'b00;
  dma_device_bank_select dma_device_bank_select_inst (.*);
  dma_far_model dma_far_model_inst (.*);
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [3:0] ex(logic c, logic [7:0] v);
    return {c, v[1], v[4], v[6]};
  endfunction
  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) rng <= xs(rng);
  task automatic chk(string n, logic [3:0] s, e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  // per-cycle model of the registered outputs, fed with pre-edge values
  always @(posedge clk_sys_in) begin
    if (mon_on) begin
      chk("bank", {3'b000, ram_bank_q_out}, {3'b000, exp_bank});
      chk("rom", {3'b000, rom_en_q_out}, 4'h0);
      chk("ack", {2'b00, scsi_ack_q_out, floppy_controller_ack_q_out}, {2'b00, exp_ack});
      chk("req", {3'b000, dma_req_q_out}, {3'b000, exp_req});
    end
    if (rst_in || ce_in) begin
      exp_bank = rst_in ? 1'b0 : (dma_mem_wr_in ? dst_bank_q_out : src_bank_q_out);
      exp_ack  = rst_in ? 2'b00 : {2{dma_ack_in}} & {dev_sel_q_out, !dev_sel_q_out};
      exp_req  = rst_in ? 1'b0 : pipe2[dev_sel_q_out];
      pipe2    = rst_in ? 2'b00 : pipe1;
      pipe1    = rst_in ? 2'b00 : {scsi_req_in, floppy_controller_req_in};
    end
    mon_on = 1'b1;
  end
  task automatic io(logic [7:0] a, v, logic w);
    @(posedge clk_sys_in);
    {io_addr_in, io_wdata_in, io_wr_in, io_rd_in} <= {a, v, w, !w};
    @(posedge clk_sys_in);
    {io_wr_in, io_rd_in} <= 2'b00;
    #1;
  endtask
  task conclude;
    $display("checked %0d mismatched %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      d = i == 0 ? 8'had : i == 1 ? 8'h52 : i == 2 ? 8'h50 : rng[7:0];
      io(8'h14, d, 1'b1);
      chk("load", seen, ex(1'b0, d));
      io(8'h14, ~d, 1'b0);
      chk("readback", seen, ex(1'b0, d));
      io(d | 8'h01, ~d, 1'b1);
      chk("decode", seen, ex(1'b0, d));
      io(8'h1a, d, i[0]);
      chk("ctrl", seen, ex(1'b1, d));
    end
    ce_in <= 1'b0;
    io(8'h14, ~d, 1'b1);
    chk("freeze", seen, ex(1'b1, d));
    ce_in <= 1'b1;
    $display("routing test done");
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    io(8'h14, 8'hff, 1'b1);
    chk("reset", seen, 4'h0);
    $display("reset test done");
    conclude;
  end
endmodule

// ==== dma_far_model.sv ====
// far side: peripherals request at random, controller acknowledges
`timescale 1ns/1ps
module dma_far_model (
  input  wire logic        clk_sys_in, dma_req_q_out,
  input  wire logic [31:0] rng,
  output logic             floppy_controller_req_in = 1'b0, scsi_req_in = 1'b0, dma_ack_in = 1'b0
);
  // ack sometimes withheld, as a busy controller would
  always @(posedge clk_sys_in) begin
    {floppy_controller_req_in, scsi_req_in} <= rng[5:4];
    dma_ack_in <= dma_req_q_out && rng[9];
  end
endmodule

// ==== dma_periph_mux.sv ====
// routes the dma request/ack handshake to the selected peripheral
`timescale 1ns/1ps
module dma_periph_mux #(
  parameter int NUM = dma_route_pkg::NUM_PERIPH
) (
  input  wire logic           clk_sys_in,
  input  wire logic           rst_in,
  input  wire logic           ce_in,
  dma_sel_if.mux              sel,
  input  wire logic [NUM-1:0] periph_req_sync_in,
  input  wire logic           dma_ack_in,
  output logic                dma_req_q,
  output logic      [NUM-1:0] periph_ack_q
);
  logic [NUM-1:0] ack_d;
  genvar g;
  generate
    for (g = 0; g < NUM; g++) begin : gen_ack
      assign ack_d[g] = dma_ack_in && (sel.dev_sel == 1'(g));
    end
  endgenerate
  wire req_d = periph_req_sync_in[sel.dev_sel];
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      dma_req_q    <= 1'b0;
      periph_ack_q <= '0;
    end else if (ce_in) begin
      dma_req_q    <= req_d;
      periph_ack_q <= ack_d;
    end
  end
endmodule

// ==== dma_route_pkg.sv ====
// constants for the dma routing and bank-select logic
package dma_route_pkg;
  localparam logic [7:0] PORT_ROUTE_SEL  = 8'h14;
  localparam logic [7:0] PORT_DMA_CTRL   = 8'h1a;
  localparam int         BIT_DEVICE      = 1;
  localparam int         BIT_SRC_BANK    = 4;
  localparam int         BIT_DST_BANK    = 6;
  localparam logic [7:0] ROUTE_RESET_VAL = 8'h00;
  localparam logic       DEV_FLOPPY      = 1'b0;
  localparam logic       DEV_SCSI        = 1'b1;
  localparam int         NUM_PERIPH      = 2;
endpackage

// ==== dma_route_sva.sv ====
// port assertions for the dma routing and bank-select block
`timescale 1ns/1ps
module dma_route_sva (
  input wire logic       clk_sys_in, rst_in, ce_in, io_wr_in, io_rd_in, dma_mem_wr_in,
  input wire logic [7:0] io_addr_in, io_wdata_in,
  input wire logic       scsi_req_in, dma_ack_in, dma_ctrl_cs_q_out, dev_sel_q_out,
  input wire logic       src_bank_q_out, dst_bank_q_out, ram_bank_q_out, rom_en_q_out,
  input wire logic       dma_req_q_out, floppy_controller_ack_q_out, scsi_ack_q_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire       w  = ce_in && io_wr_in && io_addr_in == 8'h14;
  wire       s  = (io_wr_in || io_rd_in) && io_addr_in == 8'h1a;
  wire       b  = dma_mem_wr_in ? dst_bank_q_out : src_bank_q_out;
  wire [2:0] q  = {dev_sel_q_out, src_bank_q_out, dst_bank_q_out};
  wire [2:0] wd = {io_wdata_in[1], io_wdata_in[4], io_wdata_in[6]};
  wire [1:0] k  = {scsi_ack_q_out, floppy_controller_ack_q_out};
  wire [1:0] ka = {2{dma_ack_in}} & {dev_sel_q_out, !dev_sel_q_out};
  sequence s_sc(v); ce_in && dev_sel_q_out && scsi_req_in == v; endsequence
  property p_ld; w |=> q == $past(wd); endproperty
  a_ld: assert property (p_ld) else $error("ld");
  property p_keep; !w |=> $stable(q); endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_cs; ce_in |=> dma_ctrl_cs_q_out == $past(s); endproperty
  a_cs: assert property (p_cs) else $error("cs");
  property p_rom; !rom_en_q_out; endproperty
  a_rom: assert property (p_rom) else $error("rom");
  property p_bk; ce_in |=> ram_bank_q_out == $past(b); endproperty
  a_bk: assert property (p_bk) else $error("bank");
  property p_req; s_sc(1'b1) [*3] |=> dma_req_q_out; endproperty
  a_req: assert property (p_req) else $error("req");
  property p_nreq; s_sc(1'b0) [*3] |=> !dma_req_q_out; endproperty
  a_nreq: assert property (p_nreq) else $error("nreq");
  property p_ack; ce_in |=> k == $past(ka); endproperty
  a_ack: assert property (p_ack) else $error("ack");
endmodule
bind dma_device_bank_select dma_route_sva dma_route_sva_inst (.*);

// ==== dma_sel_if.sv ====
// selection signals passed from the register to the peripheral mux
`timescale 1ns/1ps
interface dma_sel_if;
  logic dev_sel;
  modport ctrl (output dev_sel);
  modport mux  (input  dev_sel);
endinterface
